/* include/afs_pkg.sv */
// afs_pkg: states, command codes, field layouts and carriers shared by the
// adapter functional-state controller and its helper modules.
// assumes one clock domain; event fields are one-cycle pulses from logic on
// that clock.
package afs_pkg;

    // ==========================================================
    // functional states, gray along reset-ready-running-load
    typedef enum logic [3:0] {
        ST_RESET   = 4'h0,
        ST_READY   = 4'h1,
        ST_RUNNING = 4'h3,
        ST_PRIMARY = 4'h2,
        ST_SECOND  = 4'h6,
        ST_PHALT   = 4'h7,
        ST_HBHALT  = 4'h5,
        ST_NSHALT  = 4'h4,
        ST_CMBHALT = 4'hc
    } afs_state_e;

    localparam afs_state_e STATE_RST_VAL = ST_RESET;

    // ==========================================================
    // port commands carried in port_control_word_zero
    localparam int          CMD_W     = 4;
    localparam logic [3:0]  CMD_START = 4'h1;
    localparam logic [3:0]  CMD_BOOT  = 4'h2;
    localparam logic [3:0]  CMD_STOP  = 4'h3;
    localparam logic [3:0]  CMD_HALT  = 4'h4;

    // ==========================================================
    // ancillary start-microaddress function
    localparam int          ANC_W        = 4;
    localparam logic [3:0]  ANC_START_UA = 4'h1;
    localparam int          UA_W         = 12;
    localparam int          UA_SEL_HI    = 11;
    localparam int          UA_SEL_LO    = 10;
    localparam logic [1:0]  UA_SEL_READY = 2'h0;
    localparam logic [1:0]  UA_SEL_RUN   = 2'h1;
    localparam logic [1:0]  UA_SEL_LOAD  = 2'h2;
    localparam logic [1:0]  UA_SEL_PHALT = 2'h3;

    // ==========================================================
    // synchroniser
    localparam int          SYNC_W       = 2;
    localparam int          SYNC_INIT    = 0;
    localparam int          SYNC_BOOTSW  = 1;
    localparam logic [1:0]  SYNC_RST_VAL = 2'h0;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic             reset_bit;
        logic             cmd_valid;
        logic [CMD_W-1:0] cmd;
        logic             memload_xfer;
        logic             boot_frame;
        logic             dma_fatal;
        logic             int_fatal;
    } afs_evt_s;

    typedef struct packed {
        logic             valid;
        logic [ANC_W-1:0] code;
        logic [UA_W-1:0]  uaddr;
    } afs_anc_s;

    typedef struct packed {
        logic done;
        logic pass;
        logic dma_fail;
        logic net_fail;
    } afs_st_s;

endpackage

/* design/afs_sync.sv */
// afs_sync: three-flop synchroniser for pins from outside the clock domain.
// assumes a slowly changing level; a change counts once stages two and three
// agree.
`timescale 1ns/10ps
`default_nettype none

module afs_sync (
    input  wire logic                        mclk_i,
    input  wire logic                        reset_i,
    input  wire logic [afs_pkg::SYNC_W-1:0]  pin_i,
    output logic      [afs_pkg::SYNC_W-1:0]  level_o
);

    // ==========================================================
    // per-bit stages
    genvar b;
    generate
        for (b = 0; b < afs_pkg::SYNC_W; b = b + 1) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic lvl_q;
            // stage one feeds stage two only
            always_ff @(posedge mclk_i) begin
                if (reset_i) begin
                    s1_q  <= afs_pkg::SYNC_RST_VAL[b];
                    s2_q  <= afs_pkg::SYNC_RST_VAL[b];
                    s3_q  <= afs_pkg::SYNC_RST_VAL[b];
                    lvl_q <= afs_pkg::SYNC_RST_VAL[b];
                end else begin
                    s1_q <= pin_i[b];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        lvl_q <= s3_q;
                    end
                end
            end
            assign level_o[b] = lvl_q;
        end
    endgenerate

endmodule

`default_nettype wire

/* design/afs_ua_map.sv */
// afs_ua_map: picks the state a start-microaddress restart lands in.
// assumes the top two microaddress bits select the routine group.
`timescale 1ns/10ps
`default_nettype none

module afs_ua_map (
    input  wire logic [afs_pkg::UA_W-1:0] uaddr_i,
    output afs_pkg::afs_state_e           target_o
);

    // ==========================================================
    // routine group decode
    wire [1:0] sel = uaddr_i[afs_pkg::UA_SEL_HI:afs_pkg::UA_SEL_LO];

    assign target_o =
        (sel == afs_pkg::UA_SEL_READY) ? afs_pkg::ST_READY   :
        (sel == afs_pkg::UA_SEL_RUN)   ? afs_pkg::ST_RUNNING :
        (sel == afs_pkg::UA_SEL_LOAD)  ? afs_pkg::ST_PRIMARY :
                                         afs_pkg::ST_PHALT;

endmodule

`default_nettype wire

/* design/afs_fsm.sv */
// afs_fsm: functional-state controller of the host-bus network adapter.
// assumes event pulses from logic on mclk_i; bus init and boot switch are pins.
//
// What this block does
// - primary load goes to secondary load on memory-load frame with transfer.
// - start command in ready enters running.
// - boot command in ready enters primary load.
// - boot frame in ready or running enters primary load if switch enabled.
// - stop command in running returns to ready.
// - halt command in ready or running enters port halted.
// - fatal dma error in primary load, ready, running or port halted goes host-bus halted; from network halted to combined.
// - fatal internal error goes to combined halted from listed states.
// - bus init or reset bit sends every state to reset.
// - start-microaddress code 1 in port halted restarts at chosen routine.
// - combined halted answers only bus init or reset bit; host-bus halted also takes internal fatal.
// - reset leaves on selftest result: ready, host-bus, network or combined.
// - port halted blocks all network frames yet accepts port commands.
`timescale 1ns/10ps
`default_nettype none

module afs_fsm (
    input  wire logic                 mclk_i,
    input  wire logic                 reset_i,
    input  wire logic                 bus_init_i,
    input  wire logic                 boot_switch_i,
    input  wire afs_pkg::afs_evt_s    evt_i,
    input  wire afs_pkg::afs_anc_s    anc_i,
    input  wire afs_pkg::afs_st_s     st_i,
    output afs_pkg::afs_state_e       state_o,
    output logic                      net_en_o,
    output logic                      cmd_accept_o,
    output logic                      selftest_run_o,
    output logic                      clear_regs_o,
    output logic                      host_bus_halted_o,
    output logic                      network_side_halted_o
);

    // ==========================================================
    // pin synchronisation
    logic [afs_pkg::SYNC_W-1:0] pins_s;
    afs_pkg::afs_state_e        ua_target;

    afs_sync u_sync (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .pin_i   ({boot_switch_i, bus_init_i}),
        .level_o (pins_s)
    );

    afs_ua_map u_ua_map (
        .uaddr_i  (anc_i.uaddr),
        .target_o (ua_target)
    );

    // ==========================================================
    // event decode
    afs_pkg::afs_state_e state_q;
    afs_pkg::afs_state_e state_d;
    logic                st_passed_q;

    wire init_s    = pins_s[afs_pkg::SYNC_INIT];
    wire bootsw_s  = pins_s[afs_pkg::SYNC_BOOTSW];
    wire rst_src   = init_s | evt_i.reset_bit;
    wire cmd_start = evt_i.cmd_valid && (evt_i.cmd == afs_pkg::CMD_START);
    wire cmd_boot  = evt_i.cmd_valid && (evt_i.cmd == afs_pkg::CMD_BOOT);
    wire cmd_stop  = evt_i.cmd_valid && (evt_i.cmd == afs_pkg::CMD_STOP);
    wire cmd_halt  = evt_i.cmd_valid && (evt_i.cmd == afs_pkg::CMD_HALT);
    wire boot_rx   = evt_i.boot_frame && bootsw_s;
    wire ua_go     = anc_i.valid && (anc_i.code == afs_pkg::ANC_START_UA);

    wire in_rdy  = (state_q == afs_pkg::ST_READY);
    wire in_run  = (state_q == afs_pkg::ST_RUNNING);
    wire in_pld  = (state_q == afs_pkg::ST_PRIMARY);
    wire in_phl  = (state_q == afs_pkg::ST_PHALT);
    wire in_hbh  = (state_q == afs_pkg::ST_HBHALT);
    wire in_nsh  = (state_q == afs_pkg::ST_NSHALT);
    wire in_cmb  = (state_q == afs_pkg::ST_CMBHALT);
    wire in_rst  = (state_q == afs_pkg::ST_RESET);
    wire rdy_run = in_rdy | in_run;

    // fatal errors only act from the states that list them
    wire int_take = evt_i.int_fatal &&
                    (in_pld | rdy_run | in_phl | in_hbh | in_nsh);
    wire dma_take = evt_i.dma_fatal && (in_pld | rdy_run | in_phl | in_nsh);

    // retry selftest only when it failed last time
    wire st_skip = in_rst && st_passed_q;
    wire st_fin  = in_rst && !st_passed_q && st_i.done;

    wire st_ok_d = st_fin ? st_i.pass : st_passed_q;

    wire net_on = (state_d == afs_pkg::ST_READY)   ||
                  (state_d == afs_pkg::ST_RUNNING) ||
                  (state_d == afs_pkg::ST_PRIMARY) ||
                  (state_d == afs_pkg::ST_SECOND)  ||
                  (state_d == afs_pkg::ST_HBHALT);

    wire cmd_on = (state_d != afs_pkg::ST_RESET)  &&
                  (state_d != afs_pkg::ST_HBHALT) &&
                  (state_d != afs_pkg::ST_CMBHALT);

    // ==========================================================
    // next state
    always_comb begin
        state_d = state_q;
        if (rst_src) begin
            state_d = afs_pkg::ST_RESET;
        end else if (int_take) begin
            state_d = afs_pkg::ST_CMBHALT;
        end else if (dma_take) begin
            if (in_nsh) begin
                state_d = afs_pkg::ST_CMBHALT;
            end else begin
                state_d = afs_pkg::ST_HBHALT;
            end
        end else begin
            case (state_q)
                afs_pkg::ST_RESET: begin
                    if (st_skip) begin
                        state_d = afs_pkg::ST_READY;
                    end else if (st_fin) begin
                        if (st_i.pass) begin
                            state_d = afs_pkg::ST_READY;
                        end else if (st_i.dma_fail && !st_i.net_fail) begin
                            state_d = afs_pkg::ST_HBHALT;
                        end else if (st_i.net_fail && !st_i.dma_fail) begin
                            state_d = afs_pkg::ST_NSHALT;
                        end else begin
                            state_d = afs_pkg::ST_CMBHALT;
                        end
                    end
                end
                afs_pkg::ST_READY: begin
                    if (cmd_halt) begin
                        state_d = afs_pkg::ST_PHALT;
                    end else if (cmd_start) begin
                        state_d = afs_pkg::ST_RUNNING;
                    end else if (cmd_boot || boot_rx) begin
                        state_d = afs_pkg::ST_PRIMARY;
                    end
                end
                afs_pkg::ST_RUNNING: begin
                    if (cmd_halt) begin
                        state_d = afs_pkg::ST_PHALT;
                    end else if (cmd_stop) begin
                        state_d = afs_pkg::ST_READY;
                    end else if (boot_rx) begin
                        state_d = afs_pkg::ST_PRIMARY;
                    end
                end
                afs_pkg::ST_PRIMARY: begin
                    if (evt_i.memload_xfer) begin
                        state_d = afs_pkg::ST_SECOND;
                    end
                end
                afs_pkg::ST_PHALT: begin
                    // commands are taken but only a restart, a reset source or a fatal error leaves
                    if (ua_go) begin
                        state_d = ua_target;
                    end
                end
                afs_pkg::ST_HBHALT,
                afs_pkg::ST_CMBHALT: begin
                    state_d = state_q;
                end
                default: begin
                    state_d = state_q;
                end
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q     <= afs_pkg::STATE_RST_VAL;
            st_passed_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            st_passed_q <= st_ok_d;
        end
    end

    // net, command and halted outputs track the state being entered so they stay in step with it
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            net_en_o              <= 1'b0;
            cmd_accept_o          <= 1'b0;
            selftest_run_o        <= 1'b0;
            clear_regs_o          <= 1'b0;
            host_bus_halted_o     <= 1'b0;
            network_side_halted_o <= 1'b0;
        end else begin
            net_en_o              <= net_on;
            cmd_accept_o          <= cmd_on;
            selftest_run_o        <= in_rst && !st_passed_q && !st_i.done &&
                                     !rst_src;
            clear_regs_o          <= rst_src;
            host_bus_halted_o     <= (state_d == afs_pkg::ST_HBHALT) ||
                                     (state_d == afs_pkg::ST_CMBHALT);
            network_side_halted_o <= (state_d == afs_pkg::ST_NSHALT) ||
                                     (state_d == afs_pkg::ST_CMBHALT);
        end
    end

    assign state_o = state_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_quiet;
        !rst_src && !evt_i.int_fatal && !evt_i.dma_fatal;
    endsequence

    sequence s_locked_in;
        (state_q == afs_pkg::ST_HBHALT || state_q == afs_pkg::ST_CMBHALT)
        ##0 s_quiet;
    endsequence

    sequence s_st_pass;
        in_rst && !st_passed_q && st_i.done && st_i.pass;
    endsequence

    memload_a: assert property (in_pld && evt_i.memload_xfer ##0 s_quiet
        |=> state_q == afs_pkg::ST_SECOND)
        else $error("memory-load frame did not reach secondary load");

    start_a: assert property (in_rdy && cmd_start ##0 s_quiet
        |=> state_q == afs_pkg::ST_RUNNING)
        else $error("start in ready did not run");

    boot_cmd_a: assert property (in_rdy && cmd_boot ##0 s_quiet
        |=> state_q == afs_pkg::ST_PRIMARY)
        else $error("boot in ready did not load");

    boot_frame_a: assert property (rdy_run && boot_rx &&
        !evt_i.cmd_valid ##0 s_quiet |=> state_q == afs_pkg::ST_PRIMARY)
        else $error("enabled boot frame ignored");

    boot_gated_a: assert property (rdy_run && !bootsw_s &&
        !evt_i.cmd_valid |=> state_q != afs_pkg::ST_PRIMARY)
        else $error("boot frame taken with switch off");

    stop_a: assert property (in_run && cmd_stop ##0 s_quiet
        |=> state_q == afs_pkg::ST_READY)
        else $error("stop in running did not return to ready");

    // outputs follow the state entered, so check them in the same cycle
    halt_a: assert property (rdy_run && cmd_halt ##0 s_quiet
        |=> state_q == afs_pkg::ST_PHALT && !net_en_o)
        else $error("halt did not enter port halted");

    dma_halt_a: assert property (!rst_src && !evt_i.int_fatal &&
        evt_i.dma_fatal && in_nsh |=> state_q == afs_pkg::ST_CMBHALT)
        else $error("dma fatal in network halted not combined");

    int_fatal_a: assert property (!rst_src && int_take
        |=> state_q == afs_pkg::ST_CMBHALT ##0 host_bus_halted_o
        ##0 network_side_halted_o)
        else $error("internal fatal did not reach combined halted");

    reset_src_a: assert property (rst_src
        |=> state_q == afs_pkg::ST_RESET && clear_regs_o)
        else $error("reset source did not enter reset");

    ua_restart_a: assert property (in_phl && ua_go ##0 s_quiet
        |=> state_q == $past(ua_target))
        else $error("microaddress restart went astray");

    locked_a: assert property (s_locked_in ##1 s_quiet
        |-> $stable(state_q) [*2])
        else $error("halted state left without reset");

    selftest_a: assert property (s_st_pass ##0 s_quiet
        |=> in_rdy && cmd_accept_o)
        else $error("passed selftest did not reach ready");

    phalt_quiet_a: assert property (in_phl ##1 in_phl
        |-> !net_en_o && cmd_accept_o)
        else $error("port halted let frames through");

    hold_a: assert property (!rst_src && !evt_i.int_fatal &&
        !evt_i.dma_fatal && !evt_i.cmd_valid && !evt_i.boot_frame &&
        !evt_i.memload_xfer && !anc_i.valid && !in_rst
        |=> $stable(state_q))
        else $error("state moved without an event");

    priority_a: assert property (rst_src &&
        (evt_i.int_fatal || evt_i.dma_fatal) |=> in_rst)
        else $error("reset lost to a fatal error");

endmodule

`default_nettype wire

/* bench/afs_host_model.sv */
// afs_host_model: port driver on the host side of the adapter.
// assumes its tasks are called just after a falling edge of mclk_i.
`timescale 1ns/10ps
`default_nettype none

module afs_host_model (
    input  wire logic                         mclk_i,
    output logic                              bus_init_o,
    output logic                              reset_bit_o,
    output logic                              cmd_valid_o,
    output logic     [afs_pkg::CMD_W-1:0]     cmd_o,
    output afs_pkg::afs_anc_s                 anc_o
);
    // ==========================================================
    // strobes
    initial begin
        bus_init_o  = 1'b0;
        reset_bit_o = 1'b0;
        cmd_valid_o = 1'b0;
        cmd_o       = 4'h0;
        anc_o       = '0;
    end

    // strobes last one cycle; a released code shows its inverse so a stale
    // value can never pass for a live one
    always @(posedge mclk_i) begin
        if (cmd_valid_o) begin
            cmd_o <= ~cmd_o;
        end
        if (anc_o.valid) begin
            anc_o.code  <= ~anc_o.code;
            anc_o.uaddr <= ~anc_o.uaddr;
        end
        reset_bit_o <= 1'b0;
        cmd_valid_o <= 1'b0;
        anc_o.valid <= 1'b0;
    end

    // ==========================================================
    // port driver actions
    task automatic port_cmd(input logic [afs_pkg::CMD_W-1:0] code);
        cmd_o       = code;
        cmd_valid_o = 1'b1;
    endtask

    task automatic rst_word();
        reset_bit_o = 1'b1;
    endtask

    task automatic anc_fn(input logic [afs_pkg::ANC_W-1:0] code,
                          input logic [afs_pkg::UA_W-1:0]  ua);
        anc_o.code  = code;
        anc_o.uaddr = ua;
        anc_o.valid = 1'b1;
    endtask

    task automatic set_init(input logic v);
        bus_init_o = v;
    endtask
endmodule

`default_nettype wire

/* bench/tb.sv */
// tb: self-checking bench for the adapter functional-state controller.
// assumes afs_host_model plays the port driver; frames, faults and
// selftest results are driven from here.
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
    fail_count++; \
    $display("wrong value t=%0t got %h exp %h", $time, got, exp); end end

module tb;
    // ==========================================================
    // signals
    logic                 mclk_i;
    logic                 reset_i;
    logic                 boot_sw;
    logic                 ml, bf, df, inf;
    logic                 bus_init, rb, cv;
    logic [3:0]           cd;
    logic                 net_en, cmd_acc, st_run, clr, hb_halt, ns_halt;
    afs_pkg::afs_st_s     st;
    afs_pkg::afs_anc_s    anc;
    afs_pkg::afs_evt_s    evt;
    afs_pkg::afs_state_e  state_o;
    afs_pkg::afs_state_e  want_e;
    afs_pkg::afs_state_e  exp_q[$];
    afs_pkg::afs_state_e  tgt[4] = '{afs_pkg::ST_READY, afs_pkg::ST_RUNNING,
                                     afs_pkg::ST_PRIMARY, afs_pkg::ST_PHALT};
    int                   fail_count = 0;
    int                   comparisons = 0;

    assign evt = {rb, cv, cd, ml, bf, df, inf};

    afs_host_model host_u (.mclk_i(mclk_i), .bus_init_o(bus_init),
        .reset_bit_o(rb), .cmd_valid_o(cv), .cmd_o(cd), .anc_o(anc));

    afs_fsm dut_u (.mclk_i(mclk_i), .reset_i(reset_i),
        .bus_init_i(bus_init), .boot_switch_i(boot_sw), .evt_i(evt),
        .anc_i(anc), .st_i(st), .state_o(state_o), .net_en_o(net_en),
        .cmd_accept_o(cmd_acc), .selftest_run_o(st_run),
        .clear_regs_o(clr), .host_bus_halted_o(hb_halt),
        .network_side_halted_o(ns_halt));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // ==========================================================
    // tasks; c: 0 none, 1..4 port command, f reset bit
    // fr: {memload, boot frame, dma fatal, internal fatal}
    task automatic step(input logic [3:0] c, input logic [3:0] fr,
                        input logic [3:0] sv, input afs_pkg::afs_state_e e);
        if (c == 4'hf) begin
            host_u.rst_word();
        end else if (c != 4'h0) begin
            host_u.port_cmd(c);
        end
        {ml, bf, df, inf} = fr;
        st = sv;
        exp_q.push_back(e);
        @(posedge mclk_i);
        #2;
        {ml, bf, df, inf} = 4'h0;
        st = '0;
        @(negedge mclk_i);
    endtask

    task automatic rst_dut();
        reset_i = 1'b1;
        repeat (8) @(negedge mclk_i);
        reset_i = 1'b0;
        repeat (3) @(negedge mclk_i);
    endtask

    // selftest already passed, so a reset bit lands back in ready
    task automatic to_ready();
        step(4'hf, 4'h0, 4'h0, afs_pkg::ST_RESET);
        `CHK(clr, 1'b1)
        step(4'h0, 4'h0, 4'h0, afs_pkg::ST_READY);
        `CHK(net_en, 1'b1)
        `CHK(st_run, 1'b0)
    endtask

    task automatic finish_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // result watcher: one note per taking edge
    always @(posedge mclk_i) begin
        #1;
        if (exp_q.size() > 0) begin
            want_e = exp_q.pop_front();
            `CHK(state_o, want_e)
        end
    end

    initial begin
        #100us;
        fail_count++;
        finish_test();
    end

    // ==========================================================
    // scenarios
    initial begin
        reset_i = 1'b1;
        boot_sw = 1'b1;
        {ml, bf, df, inf} = 4'h0;
        st = '0;
        void'($urandom(68));
        rst_dut();
        `CHK(st_run, 1'b1)
        step(4'h0, 4'h0, 4'hc, afs_pkg::ST_READY);
        step(afs_pkg::CMD_START, 4'h0, 4'h0, afs_pkg::ST_RUNNING);
        step(afs_pkg::CMD_STOP, 4'h0, 4'h0, afs_pkg::ST_READY);
        step(afs_pkg::CMD_STOP, 4'h0, 4'h0, afs_pkg::ST_READY);
        step(afs_pkg::CMD_BOOT, 4'h0, 4'h0, afs_pkg::ST_PRIMARY);
        step(afs_pkg::CMD_START, 4'h0, 4'h0, afs_pkg::ST_PRIMARY);
        step(4'h0, 4'h8, 4'h0, afs_pkg::ST_SECOND);
        to_ready();
        step(4'h0, 4'h4, 4'h0, afs_pkg::ST_PRIMARY);
        to_ready();
        step(afs_pkg::CMD_START, 4'h0, 4'h0, afs_pkg::ST_RUNNING);
        step(4'h0, 4'h4, 4'h0, afs_pkg::ST_PRIMARY);
        to_ready();
        step(afs_pkg::CMD_START, 4'h0, 4'h0, afs_pkg::ST_RUNNING);
        boot_sw = 1'b0;
        repeat (6) @(negedge mclk_i);
        step(4'h0, 4'h4, 4'h0, afs_pkg::ST_RUNNING);
        boot_sw = 1'b1;
        repeat (6) @(negedge mclk_i);
        // restart from port halted into each routine group
        for (int s = 0; s < 4; s++) begin
            to_ready();
            if (s[0]) begin
                step(afs_pkg::CMD_START, 4'h0, 4'h0, afs_pkg::ST_RUNNING);
            end
            step(afs_pkg::CMD_HALT, 4'h0, 4'h0, afs_pkg::ST_PHALT);
            `CHK(net_en, 1'b0)
            `CHK(cmd_acc, 1'b1)
            step(afs_pkg::CMD_START, 4'hc, 4'h0, afs_pkg::ST_PHALT);
            host_u.anc_fn(4'($urandom_range(15, 2)), 12'($urandom));
            step(4'h0, 4'h0, 4'h0, afs_pkg::ST_PHALT);
            host_u.anc_fn(afs_pkg::ANC_START_UA, {2'(s), 10'($urandom)});
            step(4'h0, 4'h0, 4'h0, tgt[s]);
        end
        to_ready();
        step(afs_pkg::CMD_START, 4'h0, 4'h0, afs_pkg::ST_RUNNING);
        step(4'h0, 4'h2, 4'h0, afs_pkg::ST_HBHALT);
        `CHK(hb_halt, 1'b1)
        step(afs_pkg::CMD_START, 4'h6, 4'h0, afs_pkg::ST_HBHALT);
        step(4'h0, 4'h1, 4'h0, afs_pkg::ST_CMBHALT);
        step(afs_pkg::CMD_HALT, 4'h0, 4'h0, afs_pkg::ST_CMBHALT);
        to_ready();
        step(afs_pkg::CMD_START, 4'h3, 4'h0, afs_pkg::ST_CMBHALT);
        step(4'hf, 4'h3, 4'h0, afs_pkg::ST_RESET);
        step(4'h0, 4'h0, 4'h0, afs_pkg::ST_READY);
        step(afs_pkg::CMD_BOOT, 4'h0, 4'h0, afs_pkg::ST_PRIMARY);
        step(4'h0, 4'h2, 4'h0, afs_pkg::ST_HBHALT);
        // pin goes through the synchroniser, so allow its latency
        host_u.set_init(1'b1);
        repeat (6) @(negedge mclk_i);
        step(4'h0, 4'h0, 4'h0, afs_pkg::ST_RESET);
        host_u.set_init(1'b0);
        repeat (6) @(negedge mclk_i);
        step(4'h0, 4'h0, 4'h0, afs_pkg::ST_READY);
        // second reset in mid-run clears the selftest history
        rst_dut();
        `CHK(st_run, 1'b1)
        step(4'h0, 4'h0, 4'h9, afs_pkg::ST_NSHALT);
        `CHK(ns_halt, 1'b1)
        step(afs_pkg::CMD_START, 4'h0, 4'h0, afs_pkg::ST_NSHALT);
        step(4'h0, 4'h2, 4'h0, afs_pkg::ST_CMBHALT);
        step(4'hf, 4'h0, 4'h0, afs_pkg::ST_RESET);
        step(4'h0, 4'h0, 4'h9, afs_pkg::ST_NSHALT);
        step(4'h0, 4'h1, 4'h0, afs_pkg::ST_CMBHALT);
        step(4'hf, 4'h0, 4'h0, afs_pkg::ST_RESET);
        step(4'h0, 4'h0, 4'ha, afs_pkg::ST_HBHALT);
        step(4'hf, 4'h0, 4'h0, afs_pkg::ST_RESET);
        step(4'h0, 4'h0, 4'h8, afs_pkg::ST_CMBHALT);
        step(4'hf, 4'h0, 4'h0, afs_pkg::ST_RESET);
        step(4'h0, 4'h0, 4'hc, afs_pkg::ST_READY);
        repeat (2) @(negedge mclk_i);
        finish_test();
    end
endmodule

`default_nettype wire
